// ---- verilog/pcg_ctrl.sv ----
/*
  Global enable, overflow status and precise sampling control for two
  general counters and three fixed counters. Assumes all inputs are
  synchronous to clk_sys and that per-counter configuration words are held
  outside and presented on plain inputs.
*/
`timescale 1ns/100ps
module pcg_ctrl import pcg_pkg::*; #(
  parameter int         CW           = 40,
  parameter int         REC_WORDS    = 18,
  parameter int         MON_VERSION  = 2,
  parameter logic       TRAP_LIKE    = 1'b1
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Model register access
  input  wire logic        mreg_wr,
  input  wire logic        mreg_rd,
  input  wire logic [31:0] mreg_addr,
  input  wire logic [63:0] mreg_wdata,
  output logic      [63:0] mreg_rdata,
  output logic             mreg_rvalid,
  output logic             mreg_fault,
  // Per-counter configuration words
  input  wire logic [1:0]  gp_os_en,
  input  wire logic [1:0]  gp_usr_en,
  input  wire logic [1:0]  gp_pmi_en,
  input  wire logic [7:0]  gp0_event_sel,
  input  wire logic [7:0]  gp0_umask,
  input  wire logic [11:0] fixed_counter_config,
  input  wire logic        priv_is_kernel,
  // Event pulses
  input  wire logic [1:0]  gp_event,
  input  wire logic [2:0]  fixed_event,
  input  wire logic        gp0_event_retired,
  // Sample record writer
  input  wire logic        insn_done,
  output logic      [4:0]  arch_idx,
  input  wire logic [63:0] arch_word,
  output logic             smp_wr_valid,
  output logic      [63:0] smp_wr_data,
  input  wire logic        smp_wr_ready,
  // Branch trace store and interrupt
  input  wire logic        bts_busy,
  output logic             monitor_interrupt,
  output logic             monitor_interrupt_precise
);

  // ==========================================================================
  // Register state
  logic [63:0]    glb_en_q;
  logic [63:0]    smp_en_q;
  logic [NUM_CTR-1:0] ovf_q, ovf_d;
  logic           buf_ovf_q, buf_ovf_d;
  logic           chg_q, chg_d;
  pcg_smp_state_t state_q, state_d;
  logic [4:0]     idx_q;
  logic           pend_q, prec_q;
  logic           irq_q, irq_prec_q;
  logic [63:0]    rdata_q;
  logic           rvalid_q, fault_q;

  // Address decode.
  wire sel_en   = (mreg_addr == ADDR_GLB_EN);
  wire sel_sts  = (mreg_addr == ADDR_GLB_STS);
  wire sel_clr  = (mreg_addr == ADDR_OVF_CLR);
  wire sel_smp  = (mreg_addr == ADDR_SMP_EN);
  wire sel_cap  = (mreg_addr == ADDR_CAPS);
  logic [NUM_CTR-1:0] sel_ctr;
  wire clr_wr   = mreg_wr && sel_clr;

  // ==========================================================================
  // Counter enables and event qualification
  logic [NUM_CTR-1:0] glb_vec, priv_ok, evt_in, cnt_run, ovf_hit, pmi_vec;
  logic [NUM_CTR*CW-1:0] cnt_flat;

  assign glb_vec = {glb_en_q[GLB_FIX_LSB+2:GLB_FIX_LSB], glb_en_q[1:0]};
  assign priv_ok[1:0] = priv_is_kernel ? gp_os_en : gp_usr_en;
  assign pmi_vec[1:0] = gp_pmi_en;

  // Tagged events on counter zero count only retired work, never speculative.
  wire gp0_tagged = pcg_retire_tagged(gp0_event_sel, gp0_umask);
  assign evt_in[0] = gp_event[0] && (!gp0_tagged || gp0_event_retired);
  assign evt_in[1] = gp_event[1];
  assign evt_in[4:2] = fixed_event;

  // Fixed counters take their privilege and interrupt bits from 4-bit fields.
  for (genvar j = 0; j < 3; j++) begin : g_fix
    assign priv_ok[2+j] = fixed_counter_config[FIX_FIELD_W*j +
                          (priv_is_kernel ? FIX_OS_BIT : FIX_USR_BIT)];
    assign pmi_vec[2+j] = fixed_counter_config[FIX_FIELD_W*j + FIX_PMI_BIT];
  end

  assign cnt_run = glb_vec & priv_ok;

  // ==========================================================================
  // Counters
  // A software write wins over an increment in the same cycle, so a reload
  // never loses to a stray event.
  for (genvar i = 0; i < NUM_CTR; i++) begin : g_ctr
    logic [CW-1:0] cnt_q;
    assign sel_ctr[i] = (mreg_addr == CTR_ADDR[i]);
    wire   wr_hit     = mreg_wr && sel_ctr[i];
    wire   inc        = cnt_run[i] && evt_in[i];
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        cnt_q <= '0;
      end else if (wr_hit) begin
        cnt_q <= mreg_wdata[CW-1:0];
      end else if (inc) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
    assign ovf_hit[i] = inc && !wr_hit && (&cnt_q);
    assign cnt_flat[i*CW +: CW] = cnt_q;
  end

  // ==========================================================================
  // Precise sampling control
  // capable events only
  wire smp_armed = smp_en_q[SMP_EN_GP0_BIT] && pcg_sample_capable(gp0_event_sel, gp0_umask);
  wire smp_take  = ovf_hit[0] && smp_armed && (state_q == PCG_IDLE);
  wire last_word = (idx_q == 5'(REC_WORDS - 1));
  wire smp_done  = (state_q == PCG_WAIT_BTS) && !bts_busy;

  // Sampling walk: optional wait for instruction completion, then one
  // 64-bit entry at most every two cycles, then wait for branch trace store.
  always_comb begin
    state_d = state_q;
    case (state_q)
      PCG_IDLE: begin
        if (smp_take) state_d = TRAP_LIKE ? PCG_WAIT_INSN : PCG_LOAD;
      end
      PCG_WAIT_INSN: begin
        if (insn_done) state_d = PCG_LOAD;
      end
      PCG_LOAD: begin
        state_d = PCG_WRITE;
      end
      PCG_WRITE: begin
        if (smp_wr_ready) state_d = last_word ? PCG_WAIT_BTS : PCG_LOAD;
      end
      PCG_WAIT_BTS: begin
        if (!bts_busy) state_d = PCG_IDLE;
      end
      default: state_d = PCG_IDLE;
    endcase
  end

  // State register and record word index.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= PCG_IDLE;
      idx_q   <= '0;
    end else begin
      state_q <= state_d;
      if (state_q == PCG_IDLE) idx_q <= '0;
      else if (state_q == PCG_WRITE && smp_wr_ready) idx_q <= idx_q + 1'b1;
    end
  end

  // Record data is held in a flop so the writer sees a stable word.
  // 64-bit entries
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      smp_wr_data <= RST_ZERO;
    end else if (state_q == PCG_LOAD) begin
      smp_wr_data <= arch_word;
    end
  end

  assign smp_wr_valid = (state_q == PCG_WRITE);
  assign arch_idx     = idx_q;

  // ==========================================================================
  // Global status
  // Set wins over every clear so no overflow is lost in the clearing cycle.
  logic [NUM_CTR-1:0] clr_vec;
  for (genvar k = 0; k < NUM_CTR; k++) begin : g_clr
    assign clr_vec[k] = clr_wr && mreg_wdata[STS_BIT[k]];
  end

  always_comb begin
    ovf_d = ovf_hit | (ovf_q & ~(clr_vec | {{(NUM_CTR-1){1'b0}}, smp_done}));
    buf_ovf_d = smp_done | (buf_ovf_q & ~(clr_wr && mreg_wdata[STS_BUF_OVF_BIT]));
    chg_d     = (|ovf_hit) | smp_done | (chg_q & ~(clr_wr && mreg_wdata[STS_CHG_BIT]));
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ovf_q     <= '0;
      buf_ovf_q <= 1'b0;
      chg_q     <= 1'b0;
    end else begin
      ovf_q     <= ovf_d;
      buf_ovf_q <= buf_ovf_d;
      chg_q     <= chg_d;
    end
  end

  wire [63:0] sts_word = {chg_q, buf_ovf_q, 27'h0, ovf_q[4:2], 30'h0, ovf_q[1:0]};

  // ==========================================================================
  // Monitor interrupt
  // Requests wait while a sample or a branch trace store is in flight.
  wire pmi_req = |(ovf_hit & pmi_vec & ~{{(NUM_CTR-1){1'b0}}, smp_armed});
  wire fire    = (pend_q || prec_q) && (state_q == PCG_IDLE) && !bts_busy;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pend_q     <= 1'b0;
      prec_q     <= 1'b0;
      irq_q      <= 1'b0;
      irq_prec_q <= 1'b0;
    end else begin
      pend_q     <= pmi_req || (pend_q && !fire);
      prec_q     <= smp_done || (prec_q && !fire);
      irq_q      <= fire;
      irq_prec_q <= fire && prec_q;
    end
  end

  assign monitor_interrupt         = irq_q;
  assign monitor_interrupt_precise = irq_prec_q;

  // ==========================================================================
  // Register writes
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      glb_en_q <= RST_ZERO;
      smp_en_q <= RST_ZERO;
    end else if (mreg_wr) begin
      if (sel_en) glb_en_q <= {29'h0, mreg_wdata[34:32], 30'h0, mreg_wdata[1:0]};
      if (sel_smp) smp_en_q <= {63'h0, mreg_wdata[SMP_EN_GP0_BIT]};
    end
  end

  // ==========================================================================
  // Register reads
  // save state bit
  wire [63:0] cap_word = {52'h0, CAP_FMT_GPR_IP_FLAGS, 1'b1, TRAP_LIKE, 6'h0};
  wire        cap_ok   = (MON_VERSION >= CAP_MIN_VERSION);
  logic [63:0] ctr_rd;
  always_comb begin
    ctr_rd = RST_ZERO;
    for (int m = 0; m < NUM_CTR; m++) begin
      if (sel_ctr[m]) ctr_rd = {{(64-CW){1'b0}}, cnt_flat[m*CW +: CW]};
    end
  end

  wire rd_ok = (|sel_ctr) || sel_en || sel_sts || sel_smp || (sel_cap && cap_ok);
  wire wr_ok = (|sel_ctr) || sel_en || sel_clr || sel_smp;
  wire [63:0] rd_mux = sel_en  ? glb_en_q :
                       sel_sts ? sts_word :
                       sel_smp ? smp_en_q :
                       (sel_cap && cap_ok) ? cap_word : ctr_rd;

  // Read data is registered; a bad index answers zero with a fault pulse.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_q  <= RST_ZERO;
      rvalid_q <= 1'b0;
      fault_q  <= 1'b0;
    end else begin
      rvalid_q <= mreg_rd;
      fault_q  <= (mreg_rd && !rd_ok) || (mreg_wr && !wr_ok);
      if (mreg_rd) rdata_q <= rd_ok ? rd_mux : RST_ZERO;
    end
  end

  assign mreg_rdata  = rdata_q;
  assign mreg_rvalid = rvalid_q;
  assign mreg_fault  = fault_q;

  // ==========================================================================
  // Assertions
  wire [CW-1:0] cnt1 = cnt_flat[CW +: CW];

  property p_count_gate;
    @(posedge clk_sys) disable iff (rst)
      (!cnt_run[1] && !(mreg_wr && sel_ctr[1])) |=> (cnt1 == $past(cnt1));
  endproperty
  a_count_gate: assert property (p_count_gate)
    else $error("counter one moved while gated off");

  property p_fix_ovf;
    @(posedge clk_sys) disable iff (rst) ovf_hit[2] |=> sts_word[32];
  endproperty
  a_fix_ovf: assert property (p_fix_ovf)
    else $error("fixed overflow not reported");

  property p_clr_one;
    @(posedge clk_sys) disable iff (rst)
      (clr_wr && mreg_wdata[0] && !ovf_hit[0]) |=> !ovf_q[0];
  endproperty
  a_clr_one: assert property (p_clr_one)
    else $error("overflow clear had no effect");

  property p_clr_zero;
    @(posedge clk_sys) disable iff (rst)
      (clr_wr && !mreg_wdata[1] && ovf_q[1]) |=> ovf_q[1];
  endproperty
  a_clr_zero: assert property (p_clr_zero)
    else $error("zero bit cleared a status flag");

  property p_buf_flag;
    @(posedge clk_sys) disable iff (rst)
      (smp_done && !ovf_hit[0]) |=> buf_ovf_q && chg_q && !ovf_q[0];
  endproperty
  a_buf_flag: assert property (p_buf_flag)
    else $error("sample end did not update status");

  property p_irq_hold;
    @(posedge clk_sys) disable iff (rst)
      monitor_interrupt |-> $past(state_q == PCG_IDLE) && !$past(bts_busy);
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("interrupt raised during sample or trace store");

  property p_gp0_only;
    @(posedge clk_sys) disable iff (rst)
      (state_q == PCG_IDLE && state_d != PCG_IDLE) |-> ovf_hit[0] && smp_armed;
  endproperty
  a_gp0_only: assert property (p_gp0_only)
    else $error("sampling started without counter zero overflow");

  property p_cap_bit;
    @(posedge clk_sys) disable iff (rst)
      (mreg_rd && sel_cap && cap_ok) |=> mreg_rdata[CAP_SAVE_BIT] && mreg_rvalid;
  endproperty
  a_cap_bit: assert property (p_cap_bit)
    else $error("state save capability bit not one");

  property p_prec_irq;
    @(posedge clk_sys) disable iff (rst)
      (smp_done && !pend_q) |-> ##[1:300] monitor_interrupt_precise;
  endproperty
  a_prec_irq: assert property (p_prec_irq)
    else $error("no precise interrupt after sample");

  c_sample: cover property (@(posedge clk_sys) disable iff (rst) smp_done);
  c_clear:  cover property (@(posedge clk_sys) disable iff (rst) clr_wr && |ovf_q);
  c_irq:    cover property (@(posedge clk_sys) disable iff (rst) monitor_interrupt);

endmodule : pcg_ctrl

// ---- include/pcg_pkg.sv ----
/*
  Constants, types and decode helpers for the counter global control and
  precise sampling block. Assumes a 64-bit model register access path
  addressed by a 32-bit register index.
*/
package pcg_pkg;

  // ==========================================================================
  // Register indices
  localparam logic [31:0] ADDR_GP_CTR0   = 32'h0000_00c1;
  localparam logic [31:0] ADDR_GP_CTR1   = 32'h0000_00c2;
  localparam logic [31:0] ADDR_FIX_CTR0  = 32'h0000_0309;
  localparam logic [31:0] ADDR_FIX_CTR1  = 32'h0000_030a;
  localparam logic [31:0] ADDR_FIX_CTR2  = 32'h0000_030b;
  localparam logic [31:0] ADDR_GLB_STS   = 32'h0000_038e;
  localparam logic [31:0] ADDR_GLB_EN    = 32'h0000_038f;
  localparam logic [31:0] ADDR_OVF_CLR   = 32'h0000_0390;
  localparam logic [31:0] ADDR_SMP_EN    = 32'h0000_03f1;
  localparam logic [31:0] ADDR_CAPS      = 32'h0000_03a0;

  // ==========================================================================
  // Counter set and field positions
  localparam int NUM_CTR = 5;
  localparam logic [31:0] CTR_ADDR [NUM_CTR] = '{ADDR_GP_CTR0, ADDR_GP_CTR1,
      ADDR_FIX_CTR0, ADDR_FIX_CTR1, ADDR_FIX_CTR2};
  localparam int STS_BIT [NUM_CTR] = '{0, 1, 32, 33, 34};
  localparam int GLB_FIX_LSB     = 32;
  localparam int STS_BUF_OVF_BIT = 62;
  localparam int STS_CHG_BIT     = 63;
  localparam int SMP_EN_GP0_BIT  = 0;
  localparam int FIX_FIELD_W     = 4;
  localparam int FIX_OS_BIT      = 0;
  localparam int FIX_USR_BIT     = 1;
  localparam int FIX_PMI_BIT     = 3;
  localparam int CAP_TRAP_BIT    = 6;
  localparam int CAP_SAVE_BIT    = 7;
  localparam int CAP_FMT_LSB     = 8;
  localparam logic [3:0]  CAP_FMT_GPR_IP_FLAGS = 4'h0;
  localparam int          CAP_MIN_VERSION      = 2;
  localparam logic [63:0] RST_ZERO             = 64'h0;

  // ==========================================================================
  // Event codes
  localparam logic [7:0] EVT_LOAD_RET  = 8'hcb;
  localparam logic [7:0] EVT_ITLB_RET  = 8'hc9;
  localparam logic [7:0] UMASK_LD_MIN  = 8'h01;
  localparam logic [7:0] UMASK_LD_MAX  = 8'h10;

  typedef enum logic [2:0] {
    PCG_IDLE      = 3'b000,
    PCG_WAIT_INSN = 3'b001,
    PCG_LOAD      = 3'b010,
    PCG_WRITE     = 3'b011,
    PCG_WAIT_BTS  = 3'b100
  } pcg_smp_state_t;

  // True for events that are tagged and counted only at retirement.
  function automatic logic pcg_retire_tagged(input logic [7:0] es, input logic [7:0] um);
    pcg_retire_tagged = (es == EVT_ITLB_RET) ||
                        (es == EVT_LOAD_RET && um >= UMASK_LD_MIN && um <= UMASK_LD_MAX);
  endfunction : pcg_retire_tagged

  // True for events that may drive precise sampling.
  function automatic logic pcg_sample_capable(input logic [7:0] es, input logic [7:0] um);
    pcg_sample_capable = (es == 8'hc0 && um == 8'h00) || (es == 8'hc1 && um == 8'hfe) ||
                         (es == 8'hc5 && um == 8'h00) || (es == 8'hc7 && um == 8'h1f) ||
                         (es == EVT_LOAD_RET && (um == 8'h01 || um == 8'h02 ||
                          um == 8'h04 || um == 8'h08 || um == 8'h10));
  endfunction : pcg_sample_capable

endpackage : pcg_pkg

// ---- sim/tb.sv ----
/*
  Self-checking bench for the counter global control and precise sampling
  block: register tasks, event pulses and a sample writer with stalls.
  Assumes the package and the design module are compiled before this file.
*/
`timescale 1ns/100ps
module tb import pcg_pkg::*;;
  // ==========================================================================
  // Signals
  localparam int          RW     = 2;
  localparam logic [63:0] ONES40 = 64'h0000_00ff_ffff_ffff;
  localparam logic [63:0] WBASE  = 64'h5a00_0000_0000_0000;
  logic        clk_sys, rst, mreg_wr, mreg_rd, mreg_rvalid, mreg_fault, flt;
  logic [31:0] mreg_addr;
  logic [63:0] mreg_wdata, mreg_rdata, arch_word, smp_wr_data, rd_q;
  logic [1:0]  gp_os_en, gp_usr_en, gp_pmi_en, gp_event;
  logic [7:0]  gp0_event_sel, gp0_umask;
  logic [11:0] fixed_counter_config;
  logic [2:0]  fixed_event;
  logic [4:0]  arch_idx;
  logic        priv_is_kernel, gp0_event_retired, insn_done, smp_wr_valid, smp_wr_ready;
  logic        bts_busy, monitor_interrupt, monitor_interrupt_precise;
  int          errors, num_checks;

  pcg_ctrl #(.REC_WORDS(RW)) u_dut (
    .clk_sys(clk_sys), .rst(rst), .mreg_wr(mreg_wr), .mreg_rd(mreg_rd),
    .mreg_addr(mreg_addr), .mreg_wdata(mreg_wdata), .mreg_rdata(mreg_rdata),
    .mreg_rvalid(mreg_rvalid), .mreg_fault(mreg_fault), .gp_os_en(gp_os_en),
    .gp_usr_en(gp_usr_en), .gp_pmi_en(gp_pmi_en), .gp0_event_sel(gp0_event_sel),
    .gp0_umask(gp0_umask), .fixed_counter_config(fixed_counter_config),
    .priv_is_kernel(priv_is_kernel), .gp_event(gp_event), .fixed_event(fixed_event),
    .gp0_event_retired(gp0_event_retired), .insn_done(insn_done), .arch_idx(arch_idx),
    .arch_word(arch_word), .smp_wr_valid(smp_wr_valid), .smp_wr_data(smp_wr_data),
    .smp_wr_ready(smp_wr_ready), .bts_busy(bts_busy), .monitor_interrupt(monitor_interrupt),
    .monitor_interrupt_precise(monitor_interrupt_precise));

  // Free-running core clock, 100 ns period.
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // ==========================================================================
  // Tasks
  // Prints the verdict; every timeout also ends up here.
  task automatic summarize();
    if (errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One register access; the request stands for exactly one taking edge.
  task automatic bus(input logic wr, input logic [31:0] a, input logic [63:0] d);
    @(posedge clk_sys);
    mreg_wr    <= wr;
    mreg_rd    <= ~wr;
    mreg_addr  <= a;
    mreg_wdata <= d;
    @(posedge clk_sys);
    mreg_wr <= 1'b0;
    mreg_rd <= 1'b0;
    @(negedge clk_sys);
    rd_q = mreg_rdata;
    flt  = mreg_fault;
  endtask : bus

  task automatic rchk(input logic [31:0] a, input logic [63:0] exp);
    bus(1'b0, a, 64'h0);
    chk(rd_q, exp);
    chk({63'h0, mreg_rvalid}, 64'h1);
  endtask : rchk

  // One cycle of event pulses on the chosen counters.
  task automatic pulse(input logic [1:0] g, input logic [2:0] f);
    @(posedge clk_sys);
    gp_event    <= g;
    fixed_event <= f;
    @(posedge clk_sys);
    gp_event    <= 2'h0;
    fixed_event <= 3'h0;
  endtask : pulse

  // Reads all five counters against a table of expected counts.
  task automatic cchk(input logic [63:0] e [NUM_CTR]);
    for (int i = 0; i < NUM_CTR; i++) begin
      rchk(CTR_ADDR[i], e[i]);
    end
  endtask : cchk

  // ==========================================================================
  // Main sequence
  initial begin
    int n;
    int k;
    int st;
    logic acc;
    {rst, mreg_wr, mreg_rd, priv_is_kernel, gp0_event_retired} = 5'h10;
    {insn_done, smp_wr_ready, bts_busy} = 3'h0;
    {mreg_addr, mreg_wdata, arch_word} = '0;
    {gp_os_en, gp_usr_en, gp_pmi_en, gp_event, fixed_event} = '0;
    {gp0_event_sel, gp0_umask, fixed_counter_config} = '0;
    errors = 0;
    num_checks = 0;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    // Reset values, capability fields and refused accesses.
    rchk(ADDR_GLB_EN, 64'h0);
    rchk(ADDR_GLB_STS, 64'h0);
    bus(1'b0, ADDR_CAPS, 64'h0);
    chk(rd_q & 64'hfc0, 64'h0c0);
    bus(1'b0, ADDR_OVF_CLR, 64'h0);
    chk({63'h0, flt}, 64'h1);
    rchk(32'h0000_0123, 64'h0);
    bus(1'b1, ADDR_GLB_STS, 64'h1);
    chk({63'h0, flt}, 64'h1);
    bus(1'b1, ADDR_GLB_EN, '1);
    rchk(ADDR_GLB_EN, 64'h0000_0007_0000_0003);
    // Global enable ANDed with privilege enables; counters loaded first.
    for (int i = 0; i < NUM_CTR; i++) bus(1'b1, CTR_ADDR[i], 64'h0);
    gp_os_en <= 2'h3;
    fixed_counter_config <= 12'h321;
    priv_is_kernel <= 1'b1;
    repeat (2) pulse(2'h3, 3'h7);
    cchk('{64'h2, 64'h2, 64'h2, 64'h0, 64'h2});
    priv_is_kernel <= 1'b0;
    pulse(2'h3, 3'h7);
    cchk('{64'h2, 64'h2, 64'h2, 64'h1, 64'h3});
    priv_is_kernel <= 1'b1;
    bus(1'b1, ADDR_GLB_EN, 64'h0000_0001_0000_0001);
    pulse(2'h3, 3'h7);
    cchk('{64'h3, 64'h2, 64'h3, 64'h1, 64'h3});
    // Retirement-tagged events count only when retired; 20h is not tagged.
    gp0_event_sel <= 8'hcb;
    gp0_umask <= 8'h10;
    pulse(2'h1, 3'h0);
    rchk(ADDR_GP_CTR0, 64'h3);
    gp0_event_retired <= 1'b1;
    pulse(2'h1, 3'h0);
    rchk(ADDR_GP_CTR0, 64'h4);
    gp0_event_retired <= 1'b0;
    gp0_umask <= 8'h20;
    pulse(2'h1, 3'h0);
    rchk(ADDR_GP_CTR0, 64'h5);
    // Overflow of two counters, interrupt from the fixed one, partial clears.
    bus(1'b1, ADDR_GLB_EN, 64'h0000_0007_0000_0003);
    bus(1'b1, ADDR_FIX_CTR0, ONES40);
    bus(1'b1, ADDR_GP_CTR1, ONES40);
    fixed_counter_config <= 12'h329;
    pulse(2'h2, 3'h1);
    for (n = 0; n < 50 && monitor_interrupt !== 1'b1; n++) @(negedge clk_sys);
    chk({63'h0, monitor_interrupt_precise}, 64'h0);
    if (n == 50) begin
      errors++;
      summarize();
    end
    rchk(ADDR_GLB_STS, 64'h8000_0001_0000_0002);
    rchk(ADDR_FIX_CTR0, 64'h0);
    bus(1'b1, ADDR_OVF_CLR, 64'h0000_0001_0000_0000);
    rchk(ADDR_GLB_STS, 64'h8000_0000_0000_0002);
    bus(1'b1, ADDR_OVF_CLR, 64'h8000_0000_0000_0002);
    rchk(ADDR_GLB_STS, 64'h0);
    // Sampling armed but event not capable, and counter one overflowing too.
    bus(1'b1, ADDR_SMP_EN, 64'h1);
    rchk(ADDR_SMP_EN, 64'h1);
    gp0_event_sel <= 8'hc1;
    gp0_umask <= 8'h00;
    bus(1'b1, ADDR_GP_CTR0, ONES40);
    bus(1'b1, ADDR_GP_CTR1, ONES40);
    pulse(2'h3, 3'h0);
    repeat (20) begin
      @(negedge clk_sys);
      chk({62'h0, smp_wr_valid, monitor_interrupt_precise}, 64'h0);
    end
    rchk(ADDR_GLB_STS, 64'h8000_0000_0000_0003);
    bus(1'b1, ADDR_OVF_CLR, 64'hc000_0007_0000_0003);
    // Capable event: records with a stalling writer, trace store busy.
    gp0_event_sel <= 8'hc7;
    gp0_umask <= 8'h1f;
    bus(1'b1, ADDR_GP_CTR0, ONES40);
    k = 0;
    st = 0;
    arch_word <= WBASE;
    bts_busy <= 1'b1;
    pulse(2'h1, 3'h0);
    insn_done <= 1'b1;
    for (n = 0; n < 300; n++) begin
      @(negedge clk_sys);
      if (monitor_interrupt === 1'b1) break;
      acc = smp_wr_valid & smp_wr_ready;
      if (acc === 1'b1) begin
        chk(smp_wr_data, WBASE | 64'(k));
        chk({59'h0, arch_idx}, 64'(k));
        k++;
      end
      st = (smp_wr_valid === 1'b1 && acc !== 1'b1) ? st + 1 : 0;
      @(posedge clk_sys);
      insn_done <= (n < 3);
      smp_wr_ready <= (st >= 2);
      arch_word <= WBASE | 64'(k);
      if (n == 40) bts_busy <= 1'b0;
    end
    if (n == 300) begin
      errors++;
      summarize();
    end
    chk({62'h0, bts_busy, monitor_interrupt_precise}, 64'h1);
    chk(64'(k), 64'(RW));
    rchk(ADDR_GLB_STS, 64'hc000_0000_0000_0000);
    summarize();
  end
endmodule : tb
